// ==== rtl/fcl_loader.sv ====
// fuse byte store and start-up loader into target control registers
`timescale 1ns/100ps
`include "fcl_regs.svh"
module fcl_loader import fcl_pkg::*; #(
    parameter int unsigned MS_CYCLES = `FCL_MS_CYCLES,
    parameter logic [7:0] CAL16_A = 8'h40, // arbitrary factory values
    parameter logic [7:0] CAL16_B = 8'h08,
    parameter logic [7:0] CAL20_A = 8'h41,
    parameter logic [7:0] CAL20_B = 8'h09,
    parameter logic [7:0] ERR16_3V = 8'h00,
    parameter logic [7:0] ERR16_5V = 8'h00,
    parameter logic [7:0] ERR20_3V = 8'h00,
    parameter logic [7:0] ERR20_5V = 8'h00
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [5:0] cpu_addr,
    input wire logic cpu_rd,
    output logic [7:0] cpu_rdata,
    input wire logic [5:0] dbg_addr,
    input wire logic dbg_rd,
    input wire logic dbg_wr,
    input wire logic [7:0] dbg_wdata,
    output logic [7:0] dbg_rdata,
    output logic dbg_locked,
    output logic cpu_run,
    output logic [3:0] watchdog_window,
    output logic [3:0] watchdog_period,
    output logic [2:0] brownout_level,
    output logic brownout_sample_rate,
    output logic [1:0] brownout_active_mode,
    output logic [1:0] brownout_sleep_mode,
    output logic osc_calibration_lock,
    output logic [1:0] osc_frequency_select,
    output logic [6:0] osc_calibration_a,
    output logic [3:0] osc_calibration_b,
    output logic [1:0] flash_check_source,
    output logic reset_pin_function,
    output logic eeprom_keep_on_erase,
    output logic [2:0] startup_delay_select,
    output logic [7:0] app_code_end,
    output logic [7:0] boot_section_end
);

    // nonvolatile array: survives rst, so it holds shipped contents at power-up only
    // given as a declaration value so the write process stays its only driver
    logic [7:0] fuse_mem [0:15] = '{
        `FCL_SHIP_WDT,
        `FCL_SHIP_BOD,
        `FCL_SHIP_OSC,
        `FCL_SHIP_SYS0,
        `FCL_SHIP_SYS1,
        `FCL_SHIP_APP_CODE_END_BYTE,
        `FCL_SHIP_BOOT_SECTION_END_BYTE,
        `FCL_SHIP_LOCK,
        // spare slots, never mapped; erased cells read as ones
        8'hff,
        8'hff,
        8'hff,
        8'hff,
        8'hff,
        8'hff,
        8'hff,
        8'hff
    };
    logic [7:0] cpu_rdata_r;
    logic [7:0] dbg_rdata_r;
    logic locked_r;
    fcl_state_t state_r;
    logic [22:0] delay_cnt_r;
    // check-only helper: cycles spent in the delay state since the last load
    logic [22:0] wait_cnt_r;

    // start-up delay in cycles: 2^(code-1) ms, zero for code 0
    function automatic logic [22:0] delay_cycles(input logic [2:0] code);
        if (code == 3'h0) begin
            delay_cycles = 23'h000000;
        end else begin
            delay_cycles = 23'(MS_CYCLES << (code - 3'h1));
        end
    endfunction

    // fuse index decode; shared by both read ports and the write port
    function automatic logic [3:0] fuse_index(input logic [5:0] a);
        if (a == `FCL_OFS_WDT) fuse_index = 4'h0;
        else if (a == `FCL_OFS_BOD) fuse_index = 4'h1;
        else if (a == `FCL_OFS_OSC) fuse_index = 4'h2;
        else if (a == `FCL_OFS_SYS0) fuse_index = 4'h3;
        else if (a == `FCL_OFS_SYS1) fuse_index = 4'h4;
        else if (a == `FCL_OFS_APP_CODE_END_BYTE) fuse_index = 4'h5;
        else if (a == `FCL_OFS_BOOT_SECTION_END_BYTE) fuse_index = 4'h6;
        else if (a == `FCL_OFS_LOCK) fuse_index = 4'h7;
        else fuse_index = 4'hf;
    endfunction

    // full read map: fuses plus factory signature bytes, zero elsewhere
    function automatic logic [7:0] map_read(input logic [5:0] a, input logic [7:0] f);
        if (fuse_index(a) != 4'hf) map_read = f;
        else if (a == `FCL_OFS_CAL16A) map_read = {1'b0, CAL16_A[6:0]};
        else if (a == `FCL_OFS_CAL16B) map_read = {4'h0, CAL16_B[3:0]};
        else if (a == `FCL_OFS_CAL20A) map_read = {1'b0, CAL20_A[6:0]};
        else if (a == `FCL_OFS_CAL20B) map_read = {4'h0, CAL20_B[3:0]};
        else if (a == `FCL_OFS_ERR16_3V) map_read = ERR16_3V;
        else if (a == `FCL_OFS_ERR16_5V) map_read = ERR16_5V;
        else if (a == `FCL_OFS_ERR20_3V) map_read = ERR20_3V;
        else if (a == `FCL_OFS_ERR20_5V) map_read = ERR20_5V;
        else map_read = 8'h00;
    endfunction

    // only the debug port writes; cpu has no write path at all
    always_ff @(posedge mclk) begin
        if (dbg_wr && !locked_r && fuse_index(dbg_addr) != 4'hf) begin
            fuse_mem[fuse_index(dbg_addr)] <= dbg_wdata; // reserved ones kept as written
        end
    end

    // cpu read port works even in reset, so fuses are visible from power-up
    always_ff @(posedge mclk) begin
        cpu_rdata_r <= cpu_rd ? map_read(cpu_addr, fuse_mem[fuse_index(cpu_addr)]) : 8'h00;
    end

    // locked debug reads return zero instead of data
    always_ff @(posedge mclk) begin
        if (dbg_rd && !locked_r) begin
            dbg_rdata_r <= map_read(dbg_addr, fuse_mem[fuse_index(dbg_addr)]);
        end else begin
            dbg_rdata_r <= 8'h00;
        end
    end

    assign cpu_rdata = cpu_rdata_r;
    assign dbg_rdata = dbg_rdata_r;
    assign dbg_locked = locked_r;

    // start-up sequence: load all fields, wait the delay, then release cpu
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_r <= FCL_LOAD;
            delay_cnt_r <= 23'h000000;
            cpu_run <= 1'b0;
        end else begin
            case (state_r)
                FCL_LOAD: begin
                    // delay taken from the stored code, not from the target copy
                    delay_cnt_r <= delay_cycles(fuse_mem[4][2:0]);
                    state_r <= FCL_DELAY;
                end
                FCL_DELAY: begin
                    if (delay_cnt_r == 23'h000000) begin
                        state_r <= FCL_RUN;
                        cpu_run <= 1'b1;
                    end else begin
                        delay_cnt_r <= delay_cnt_r - 23'h000001;
                    end
                end
                default: begin
                    cpu_run <= 1'b1;
                end
            endcase
        end
    end

    // targets load once in the load state; later fuse writes wait for reset
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            watchdog_window <= 4'h0;
            watchdog_period <= 4'h0;
            brownout_level <= 3'h0;
            brownout_sample_rate <= 1'b0;
            brownout_active_mode <= 2'h0;
            brownout_sleep_mode <= 2'h0;
            osc_calibration_lock <= 1'b0;
            osc_frequency_select <= 2'h0;
            osc_calibration_a <= 7'h00;
            osc_calibration_b <= 4'h0;
            flash_check_source <= 2'h0;
            reset_pin_function <= 1'b0;
            eeprom_keep_on_erase <= 1'b0;
            startup_delay_select <= 3'h0;
            app_code_end <= 8'h00;
            boot_section_end <= 8'h00;
            locked_r <= 1'b1;
        end else if (state_r == FCL_LOAD) begin
            watchdog_window <= fuse_mem[0][7:4];
            watchdog_period <= fuse_mem[0][3:0];
            brownout_level <= fuse_mem[1][7:5];
            brownout_sample_rate <= fuse_mem[1][4];
            brownout_active_mode <= fuse_mem[1][3:2];
            brownout_sleep_mode <= fuse_mem[1][1:0];
            osc_calibration_lock <= fuse_mem[2][7];
            osc_frequency_select <= fuse_mem[2][1:0];
            // reserved frequency codes fall back to 20 MHz calibration bytes
            if (fuse_mem[2][1:0] == `FCL_FREQ_16M) begin
                osc_calibration_a <= CAL16_A[6:0];
                osc_calibration_b <= CAL16_B[3:0];
            end else begin
                osc_calibration_a <= CAL20_A[6:0];
                osc_calibration_b <= CAL20_B[3:0];
            end
            flash_check_source <= fuse_mem[3][7:6];
            reset_pin_function <= fuse_mem[3][3];
            // locked device always erases eeprom, so report keep as off
            eeprom_keep_on_erase <= fuse_mem[3][0] && (fuse_mem[7] == `FCL_LOCK_KEY);
            startup_delay_select <= fuse_mem[4][2:0];
            app_code_end <= fuse_mem[5];
            boot_section_end <= fuse_mem[6];
            locked_r <= (fuse_mem[7] != `FCL_LOCK_KEY);
        end
    end

    // helper counter for the delay-length check; cleared by every reset
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wait_cnt_r <= 23'h000000;
        end else if (state_r == FCL_DELAY && !cpu_run) begin
            wait_cnt_r <= wait_cnt_r + 23'h000001;
        end
    end

    a_run_after_load: assert property (@(posedge mclk) disable iff (rst)
        cpu_run |-> state_r != FCL_LOAD)
        else $error("cpu released before fields loaded");
    a_targets_hold: assert property (@(posedge mclk) disable iff (rst)
        $past(state_r) == FCL_RUN |-> $stable(watchdog_period) && $stable(brownout_level))
        else $error("target changed without reset");
    a_lock_key: assert property (@(posedge mclk) disable iff (rst)
        state_r == FCL_LOAD |=> locked_r == ($past(fuse_mem[7]) != `FCL_LOCK_KEY))
        else $error("lock state does not follow key");
    a_wdt_copy: assert property (@(posedge mclk) disable iff (rst)
        state_r == FCL_LOAD |=> {watchdog_window, watchdog_period} == $past(fuse_mem[0]))
        else $error("watchdog byte not copied");
    a_bod_copy: assert property (@(posedge mclk) disable iff (rst)
        state_r == FCL_LOAD |=> {brownout_level, brownout_sample_rate, brownout_active_mode,
        brownout_sleep_mode} == $past(fuse_mem[1]))
        else $error("brown-out byte not copied");
    a_osc_copy: assert property (@(posedge mclk) disable iff (rst)
        state_r == FCL_LOAD |=> osc_calibration_lock == $past(fuse_mem[2][7]))
        else $error("oscillator lock not copied");
    a_sys0_copy: assert property (@(posedge mclk) disable iff (rst)
        state_r == FCL_LOAD |=> flash_check_source == $past(fuse_mem[3][7:6])
        && reset_pin_function == $past(fuse_mem[3][3]))
        else $error("system byte not copied");
    a_no_zero_delay: assert property (@(posedge mclk) disable iff (rst)
        state_r == FCL_LOAD && fuse_mem[4][2:0] != 3'h0 |=> !cpu_run [*2])
        else $error("start-up delay too short");

    // the processor is let go one cycle more than the delay after the load edge
    a_delay_length: assert property (@(posedge mclk) disable iff (rst)
        $rose(cpu_run) |-> wait_cnt_r == delay_cycles(startup_delay_select) + 23'h000001)
        else $error("start-up delay length wrong");

    // once released, the processor stays released until the next reset
    a_run_stays: assert property (@(posedge mclk) disable iff (rst)
        cpu_run |=> cpu_run)
        else $error("processor dropped back into start-up");

    // frequency code passes through as stored, reserved codes too
    a_freq_copy: assert property (@(posedge mclk) disable iff (rst)
        state_r == FCL_LOAD |=> osc_frequency_select == $past(fuse_mem[2][1:0]))
        else $error("frequency code not copied");

    // 16 MHz code picks the 16 MHz factory calibration pair
    a_cal_pick16: assert property (@(posedge mclk) disable iff (rst)
        state_r == FCL_LOAD && fuse_mem[2][1:0] == `FCL_FREQ_16M |=>
        osc_calibration_a == CAL16_A[6:0] && osc_calibration_b == CAL16_B[3:0])
        else $error("16 MHz calibration not loaded");

    // 20 MHz code picks the 20 MHz factory calibration pair
    a_cal_pick20: assert property (@(posedge mclk) disable iff (rst)
        state_r == FCL_LOAD && fuse_mem[2][1:0] == `FCL_FREQ_20M |=>
        osc_calibration_a == CAL20_A[6:0] && osc_calibration_b == CAL20_B[3:0])
        else $error("20 MHz calibration not loaded");

    // a locked device never reports eeprom as kept
    a_keep_locked: assert property (@(posedge mclk) disable iff (rst)
        locked_r |-> !eeprom_keep_on_erase)
        else $error("eeprom keep while locked");

    // start-up code is reported to its target as stored
    a_sys1_copy: assert property (@(posedge mclk) disable iff (rst)
        state_r == FCL_LOAD |=> startup_delay_select == $past(fuse_mem[4][2:0]))
        else $error("start-up code not copied");

    // section ends go to the flash controller unchanged
    a_ends_copy: assert property (@(posedge mclk) disable iff (rst)
        state_r == FCL_LOAD |=> app_code_end == $past(fuse_mem[5])
        && boot_section_end == $past(fuse_mem[6]))
        else $error("section ends not copied");

    // idle read port returns zero so stale bytes never linger
    a_cpu_rd_idle: assert property (@(posedge mclk) disable iff (rst)
        !cpu_rd |=> cpu_rdata == 8'h00)
        else $error("cpu read data without request");

    a_locked_dbg_read: assert property (@(posedge mclk) disable iff (rst)
        locked_r && dbg_rd |=> dbg_rdata == 8'h00)
        else $error("debug read while locked");
    c_release: cover property (@(posedge mclk) disable iff (rst) $rose(cpu_run));
    c_locked: cover property (@(posedge mclk) disable iff (rst) cpu_run && locked_r);
    c_freq16: cover property (@(posedge mclk) disable iff (rst)
        cpu_run && osc_frequency_select == `FCL_FREQ_16M);
    c_reserved_level: cover property (@(posedge mclk) disable iff (rst)
        cpu_run && brownout_level == 3'h3);
    c_reset_pin: cover property (@(posedge mclk) disable iff (rst)
        cpu_run && reset_pin_function && eeprom_keep_on_erase);

endmodule // fcl_loader

// ==== rtl/fcl_regs.svh ====
// fuse loader constants: offsets, shipped values, lock key, frequency codes, timing
//Function
//- cpu and debug port read the fuse bytes; only debug port writes them
//- fuse bytes readable from power-up, before any software runs
//- at start of start-up, before the delay, copy each fuse field to its target register
//- newly written fuse values take effect only after the next reset
//- watchdog byte upper nibble to window, lower nibble to period
//- brown-out level bits 7:5 copied to detector level setting
//- brown-out sample-rate bit copied, zero 1 kHz, one 125 Hz
//- active/idle brown-out mode bits 3:2 copied to detector control
//- sleep brown-out mode bits 1:0 copied to detector control
//- oscillator lock bit copied to lock flag of calibration register b
//- frequency select picks 16 or 20 MHz and its calibration bytes
//- flash check source bits 7:6 choose region checked at reset
//- reset-pin bit selects gpio when zero, reset input when one
//- eeprom kept on chip erase when bit set, unless device locked
//- read-only factory bytes report signed oscillator frequency error
//- shipped fuse contents differ from register reset values
//- start-up delay code selects 0 to 64 ms before code runs
//- device open only when lock byte holds key 0xc5
`ifndef FCL_REGS_SVH
`define FCL_REGS_SVH

`define FCL_OFS_WDT 6'h00
`define FCL_OFS_BOD 6'h01
`define FCL_OFS_OSC 6'h02
`define FCL_OFS_SYS0 6'h05
`define FCL_OFS_SYS1 6'h06
`define FCL_OFS_APP_CODE_END_BYTE 6'h07
`define FCL_OFS_BOOT_SECTION_END_BYTE 6'h08
`define FCL_OFS_LOCK 6'h0a
`define FCL_OFS_CAL16A 6'h18
`define FCL_OFS_CAL16B 6'h19
`define FCL_OFS_CAL20A 6'h1a
`define FCL_OFS_CAL20B 6'h1b
`define FCL_OFS_ERR16_3V 6'h22
`define FCL_OFS_ERR16_5V 6'h23
`define FCL_OFS_ERR20_3V 6'h24
`define FCL_OFS_ERR20_5V 6'h25
`define FCL_NUM_FUSE 11

`define FCL_SHIP_WDT 8'h00
`define FCL_SHIP_BOD 8'h00
`define FCL_SHIP_OSC 8'h02
`define FCL_SHIP_SYS0 8'he4
`define FCL_SHIP_SYS1 8'h07
`define FCL_SHIP_APP_CODE_END_BYTE 8'h00
`define FCL_SHIP_BOOT_SECTION_END_BYTE 8'h00
`define FCL_SHIP_LOCK 8'hc5

`define FCL_LOCK_KEY 8'hc5
`define FCL_FREQ_16M 2'h1
`define FCL_FREQ_20M 2'h2

`define FCL_CLK_KHZ 10000
`define FCL_MS_CYCLES (`FCL_CLK_KHZ)

`endif

// ==== rtl/fcl_pkg.sv ====
// fuse loader types
package fcl_pkg;
    typedef enum logic [1:0] {
        FCL_LOAD,
        FCL_DELAY,
        FCL_RUN
    } fcl_state_t;
endpackage

// ==== testbench/fcl_prog_model.sv ====
// debug programmer model driving the fuse write and read port
`timescale 1ns/100ps
module fcl_prog_model (
    input wire logic mclk,
    output logic [5:0] dbg_addr,
    output logic dbg_rd,
    output logic dbg_wr,
    output logic [7:0] dbg_wdata,
    input wire logic [7:0] dbg_rdata
);
    // reserved bits of each fuse byte, always programmed as one
    function automatic logic [7:0] rsv(input logic [5:0] a);
        case (a)
            6'h02: rsv = 8'h7c;
            6'h05: rsv = 8'h36;
            6'h06: rsv = 8'hf8;
            default: rsv = 8'h00;
        endcase
    endfunction
    initial begin
        dbg_addr = 6'h00;
        dbg_rd = 1'b0;
        dbg_wr = 1'b0;
        dbg_wdata = 8'h00;
    end
    // one byte write; idle data flips so a stale byte is never taken twice
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge mclk);
        dbg_addr = a;
        dbg_wdata = d | rsv(a);
        dbg_wr = 1'b1;
        @(negedge mclk);
        dbg_wr = 1'b0;
        dbg_wdata = ~dbg_wdata;
    endtask
    // one byte read, data taken one cycle after the request
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(negedge mclk);
        dbg_addr = a;
        dbg_rd = 1'b1;
        @(negedge mclk);
        d = dbg_rdata;
        dbg_rd = 1'b0;
    endtask
endmodule // fcl_prog_model

// ==== testbench/tb_fuse_config_loader.sv ====
// self-checking bench for the fuse loader
`timescale 1ns/100ps
module tb_fuse_config_loader;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [5:0] cpu_addr = 6'h00;
    logic cpu_rd = 1'b0;
    logic [5:0] dbg_addr;
    logic dbg_rd, dbg_wr, dbg_locked, cpu_run, samp, olock, rpin, ekeep;
    logic [7:0] dbg_wdata, cpu_rdata, dbg_rdata, app_end, boot_end, d;
    logic [3:0] wwin, wper, ocb;
    logic [2:0] blvl, sdel;
    logic [1:0] bact, bslp, ofs, fcs;
    logic [6:0] oca;
    int mismatches = 0;
    int n_checks = 0;
    int cycles = 0;
    // read address beside the byte expected from the shipped contents
    logic [13:0] rows [14] = '{{6'h00, 8'h00}, {6'h01, 8'h00}, {6'h02, 8'h02},
        {6'h05, 8'he4}, {6'h06, 8'h07}, {6'h07, 8'h00}, {6'h08, 8'h00}, {6'h0a, 8'hc5},
        {6'h09, 8'h00}, {6'h18, 8'h40}, {6'h23, 8'h11}, {6'h24, 8'hf2}, {6'h25, 8'h83},
        {6'h3f, 8'h00}};
    always #50 mclk = ~mclk;
    // short millisecond so the 64 ms shipped delay stays cheap
    fcl_loader #(.MS_CYCLES(4), .ERR16_5V(8'h11), .ERR20_3V(8'hf2), .ERR20_5V(8'h83)) dut (
        .mclk(mclk), .rst(rst), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata),
        .dbg_addr(dbg_addr), .dbg_rd(dbg_rd), .dbg_wr(dbg_wr), .dbg_wdata(dbg_wdata),
        .dbg_rdata(dbg_rdata), .dbg_locked(dbg_locked), .cpu_run(cpu_run),
        .watchdog_window(wwin), .watchdog_period(wper), .brownout_level(blvl),
        .brownout_sample_rate(samp), .brownout_active_mode(bact), .brownout_sleep_mode(bslp),
        .osc_calibration_lock(olock), .osc_frequency_select(ofs), .osc_calibration_a(oca),
        .osc_calibration_b(ocb), .flash_check_source(fcs), .reset_pin_function(rpin),
        .eeprom_keep_on_erase(ekeep), .startup_delay_select(sdel), .app_code_end(app_end),
        .boot_section_end(boot_end));
    fcl_prog_model prog (.mclk(mclk), .dbg_addr(dbg_addr), .dbg_rd(dbg_rd), .dbg_wr(dbg_wr),
        .dbg_wdata(dbg_wdata), .dbg_rdata(dbg_rdata));
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask
    task automatic chk_n(input string nm, input int e, input int g);
        n_checks++;
        if (g != e) begin
            mismatches++;
            $display("unexpected %s: expected %0d, seen %0d", nm, e, g);
        end
    endtask
    task automatic cpu_read(input logic [5:0] a, output logic [7:0] q);
        @(negedge mclk);
        cpu_addr = a;
        cpu_rd = 1'b1;
        @(negedge mclk);
        q = cpu_rdata;
        cpu_rd = 1'b0;
    endtask
    // reset for 5 cycles, then count edges until the processor is let go
    task automatic do_reset(input int exp_edges);
        int k;
        k = 0;
        @(negedge mclk);
        rst = 1'b1;
        repeat (5) @(negedge mclk);
        chk("reset state", 8'h01, {blvl, wwin, dbg_locked});
        chk("run in reset", 8'h00, {7'h0, cpu_run});
        rst = 1'b0;
        while (cpu_run !== 1'b1 && k < 400) begin
            @(negedge mclk);
            k++;
        end
        chk_n("run edge", exp_edges, k);
    endtask
    task automatic end_sim;
        $display("checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // hang guard, well above the roughly 350 cycles the sequence needs
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            end_sim();
        end
    end
    initial begin
        do_reset(2 + (4 << 6));
        for (int i = 0; i < 14; i++) begin
            cpu_read(rows[i][13:8], d);
            chk("cpu byte", rows[i][7:0], d);
        end
        prog.rd(6'h05, d);
        chk("dbg byte", 8'he4, d);
        // program new values; targets must hold the old ones until reset
        prog.wr(6'h00, 8'ha5);
        prog.wr(6'h01, 8'h7e);
        prog.wr(6'h02, 8'h81);
        prog.wr(6'h05, 8'h89);
        prog.wr(6'h06, 8'h02);
        prog.wr(6'h07, 8'h12);
        prog.wr(6'h08, 8'h34);
        cpu_read(6'h02, d);
        chk("osc byte", 8'hfd, d);
        chk("held", 8'h20, {2'h0, ofs, wper});
        do_reset(2 + (4 << 1));
        chk("wdt", 8'ha5, {wwin, wper});
        chk("bod", 8'h7e, {blvl, samp, bact, bslp});
        chk("osc", 8'h81, {olock, 5'h0, ofs});
        chk("cal", 8'h88, {oca[6:3], ocb});
        chk("sys0", 8'h89, {fcs, 2'h0, rpin, 2'h0, ekeep});
        chk("ends", 8'h46, app_end + boot_end);
        chk("open", 8'h02, {dbg_locked, sdel});
        prog.wr(6'h0a, 8'h00);
        do_reset(2 + 8);
        chk("locked", 8'h01, {7'h0, dbg_locked});
        chk("keep", 8'h00, {7'h0, ekeep});
        prog.rd(6'h05, d);
        chk("dbg locked read", 8'h00, d);
        prog.wr(6'h07, 8'h55);
        cpu_read(6'h07, d);
        chk("write refused", 8'h12, d);
        cpu_read(6'h0a, d);
        chk("cpu lock byte", 8'h00, d);
        end_sim();
    end
endmodule // tb_fuse_config_loader
